// ==== cas_consts.svh ====
// constants for the cpu alu status datapath
`ifndef CAS_CONSTS_SVH
`define CAS_CONSTS_SVH
`define CAS_SR_DC_BIT    8
`define CAS_SR_PRI_HI    7
`define CAS_SR_PRI_LO    5
`define CAS_SR_RA_BIT    4
`define CAS_SR_N_BIT     3
`define CAS_SR_OV_BIT    2
`define CAS_SR_Z_BIT     1
`define CAS_SR_C_BIT     0
`define CAS_CC_EXT_BIT   3
`define CAS_CC_PSV_BIT   2
`define CAS_SR_RESET     16'h0000
`define CAS_CC_RESET     16'h0000
`define CAS_PRI_TOP      3'h7
`define CAS_DIV_CYCLES   5'h13
`endif

// ==== cas_pkg.sv ====
// types for the cpu alu status datapath
package cas_pkg;
  typedef enum logic [3:0] {
    CAS_OP_ADD = 4'h0,
    CAS_OP_SUB = 4'h1,
    CAS_OP_AND = 4'h2,
    CAS_OP_OR  = 4'h3,
    CAS_OP_XOR = 4'h4,
    CAS_OP_ASR = 4'h5,
    CAS_OP_LSR = 4'h6,
    CAS_OP_SL  = 4'h7,
    CAS_OP_MOV = 4'h8
  } cas_op_t;
  typedef enum logic [2:0] {
    CAS_MUL_SS  = 3'h0,
    CAS_MUL_UU  = 3'h1,
    CAS_MUL_SU5 = 3'h2,
    CAS_MUL_UU5 = 3'h3,
    CAS_MUL_US  = 3'h4,
    CAS_MUL_BB  = 3'h5
  } cas_mul_t;
  typedef enum logic [1:0] {
    CAS_DIV_IDLE = 2'b00,
    CAS_DIV_RUN  = 2'b01,
    CAS_DIV_FIX  = 2'b10
  } cas_div_st_t;
  typedef struct packed {
    logic        valid;
    cas_op_t     op;
    logic        byte_mode;
    logic        src_mem;
    logic        dst_mem;
    logic        cnt_lit;
    logic [3:0]  lit_cnt;
  } cas_alu_req_t;
  typedef struct packed {
    logic        wr_work;
    logic        wr_mem;
    logic [15:0] data;
  } cas_alu_res_t;
endpackage : cas_pkg

// ==== cas_datapath.sv ====
// alu datapath with status and core control registers
`timescale 1ns/1ps
`include "cas_consts.svh"
// Overview of operation
// RULE1 - half carry set on carry out of bit 3 (byte) or bit 7 (word)
// RULE2 - priority field in status bits 7..5; extension selects levels 8..15
// RULE3 - priority field is read-only while nesting_off_bit is set
// RULE4 - cpu priority is extension bit above the three field bits
// RULE5 - user interrupts inhibited when extension set or level code 111
// RULE6 - repeat active flag in bit 4, read-only, mirrors repeat loop
// RULE7 - negative flag in bit 3 follows result sign
// RULE8 - signed wrap flag in bit 2 marks two's complement overflow
// RULE9 - zero flag set by zero result, cleared by a non-zero one; a status register write loads it from wdata_i bit 1 unless alu_fire is set
// RULE10 - carry flag in bit 0 is carry out of the top bit
// RULE11 - on subtraction carry and half carry mean no borrow
// RULE12 - status bits 15..9 read zero; all status bits reset to zero
// RULE13 - extension bit at control bit 3, clear-only by software
// RULE14 - control bit 2 enables the program memory data window
// RULE15 - add, sub, shift and logic on byte or word width
// RULE16 - operands from work registers or memory, result to either
// RULE17 - 17x17 multiplier with signed, unsigned, mixed, literal, byte modes
// RULE18 - divider signed and unsigned 32/16, 16/16; quotient and remainder out
// RULE19 - divisor any work reg, dividend from even/odd pair, odd is high
// RULE20 - divider runs one cycle per divisor bit, same for both sizes
// RULE21 - every divide takes 19 cycles and can be interrupted
// RULE22 - single-cycle shifter up to 15 bits left or arithmetic right
// RULE23 - multi-bit shifts use only register direct operands
// RULE24 - shift count from register or literal, single or multi-bit
// RULE25 - arithmetic right fills sign, logical right and left fill zero
module cas_datapath
  import cas_pkg::*;
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // alu request
  input  wire cas_alu_req_t req_i,
  input  wire logic [15:0]  work_opnd_i,
  input  wire logic [15:0]  mem_opnd_i,
  input  wire logic [15:0]  opnd_b_i,
  output cas_alu_res_t      res_o,
  output logic              shift_mode_err_o,
  // multiplier
  input  wire logic         mul_go_i,
  input  wire cas_mul_t     mul_mode_i,
  input  wire logic [15:0]  mul_a_i,
  input  wire logic [15:0]  mul_b_i,
  output logic [31:0]       mul_prod_o,
  // divider
  input  wire logic         div_go_i,
  input  wire logic         div_signed_i,
  input  wire logic         div_long_i,
  input  wire logic         div_abort_i,
  input  wire logic [15:0]  div_even_i,
  input  wire logic [15:0]  div_odd_i,
  input  wire logic [15:0]  div_divisor_i,
  output logic              div_busy_o,
  output logic              div_done_o,
  output logic [15:0]       first_work_reg_o,
  output logic [15:0]       second_work_reg_o,
  // register access
  input  wire logic         sr_we_i,
  input  wire logic         cc_we_i,
  input  wire logic [15:0]  wdata_i,
  input  wire logic         nesting_off_bit_i,
  input  wire logic         repeat_busy_i,
  input  wire logic         pri_raise_i,
  input  wire logic [3:0]   pri_new_i,
  output logic [15:0]       alu_status_o,
  output logic [15:0]       core_control_o,
  output logic [3:0]        cpu_priority_o,
  output logic              user_irq_block_o,
  output logic              program_window_enable_o
);
  // ------------------------------------------------------------
  // alu
  // ------------------------------------------------------------
  logic [15:0] opa;
  logic [15:0] opb;
  logic [16:0] sum;
  logic        hc_raw;
  logic [15:0] lres;
  logic [3:0]  shamt;
  logic [15:0] shifted;
  logic        msb;
  logic        is_arith;
  logic        is_sub;
  logic [4:0]  low_b;
  logic [8:0]  low_w;

  assign opa      = req_i.src_mem ? mem_opnd_i : work_opnd_i;  // RULE16
  assign is_sub   = (req_i.op == CAS_OP_SUB);
  assign opb      = is_sub ? ~opnd_b_i : opnd_b_i;
  // subtract as a + ~b + 1 so carry reads as not-borrow
  assign sum      = {1'b0, opa} + {1'b0, opb} + {16'h0000, is_sub};  // RULE11
  assign low_b    = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, is_sub};
  assign low_w    = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, is_sub};
  assign hc_raw   = req_i.byte_mode ? low_b[4] : low_w[8];  // RULE1
  assign shamt    = req_i.cnt_lit ? req_i.lit_cnt : opnd_b_i[3:0];  // RULE24
  assign is_arith = (req_i.op == CAS_OP_ADD) || is_sub;

  // byte mode sign-extends so an arithmetic right shift fills from bit 7
  logic [15:0] sh_src;
  assign sh_src = req_i.byte_mode ? {{8{opa[7]}}, opa[7:0]} : opa;

  always_comb begin
    shifted = sh_src;
    unique case (req_i.op)
      CAS_OP_ASR: shifted = 16'($signed(sh_src) >>> shamt);  // RULE22 RULE25
      CAS_OP_LSR: shifted = (req_i.byte_mode ? {8'h00, opa[7:0]} : opa) >> shamt;  // RULE25
      CAS_OP_SL:  shifted = opa << shamt;  // RULE22
      default:    shifted = sh_src;
    endcase
  end

  always_comb begin
    lres = 16'h0000;
    unique case (req_i.op)  // RULE15
      CAS_OP_ADD, CAS_OP_SUB: lres = sum[15:0];
      CAS_OP_AND: lres = opa & opnd_b_i;
      CAS_OP_OR:  lres = opa | opnd_b_i;
      CAS_OP_XOR: lres = opa ^ opnd_b_i;
      CAS_OP_ASR, CAS_OP_LSR, CAS_OP_SL: lres = shifted;
      default:    lres = opa;
    endcase
  end

  logic [15:0] rmask;
  logic        carry_raw;
  logic        ov_raw;
  logic        is_shift;
  assign rmask     = req_i.byte_mode ? {8'h00, lres[7:0]} : lres;
  assign msb       = req_i.byte_mode ? lres[7] : lres[15];
  assign carry_raw = req_i.byte_mode ? (opa[7:0] + opb[7:0] + {7'h00, is_sub}) > 9'h0FF : sum[16];  // RULE10
  assign ov_raw    = req_i.byte_mode ? ((opa[7] == opb[7]) && (lres[7] != opa[7]))
                                     : ((opa[15] == opb[15]) && (lres[15] != opa[15]));  // RULE8
  assign is_shift  = (req_i.op == CAS_OP_ASR) || (req_i.op == CAS_OP_LSR) || (req_i.op == CAS_OP_SL);
  // multi-bit shifts reject memory operands and do nothing
  assign shift_mode_err_o = req_i.valid && is_shift && (req_i.src_mem || req_i.dst_mem);  // RULE23
  logic alu_fire;
  assign alu_fire = req_i.valid && !shift_mode_err_o;

  cas_alu_res_t res_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_reg <= '0;
    end else begin
      res_reg.wr_work <= alu_fire && !req_i.dst_mem;  // RULE16
      res_reg.wr_mem  <= alu_fire && req_i.dst_mem;
      res_reg.data    <= rmask;
    end
  end
  assign res_o = res_reg;

  // ------------------------------------------------------------
  // status and core control
  // ------------------------------------------------------------
  logic       dc_reg, n_reg, ov_reg, z_reg, c_reg, ra_reg, ext_reg, psv_reg;
  logic [2:0] pri_reg;
  logic [2:0] pri_next;
  logic       ext_next;

  always_comb begin
    pri_next = pri_reg;
    ext_next = ext_reg;
    if (sr_we_i && !nesting_off_bit_i) pri_next = wdata_i[`CAS_SR_PRI_HI:`CAS_SR_PRI_LO];  // RULE3
    if (cc_we_i && !wdata_i[`CAS_CC_EXT_BIT]) ext_next = 1'b0;  // RULE13
    if (pri_raise_i) begin
      pri_next = pri_new_i[2:0];
      ext_next = pri_new_i[3];  // RULE13
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {dc_reg, n_reg, ov_reg, z_reg, c_reg} <= 5'h00;  // RULE12
      ra_reg  <= 1'b0;
      pri_reg <= 3'h0;
      ext_reg <= 1'b0;
      psv_reg <= 1'b0;
    end else begin
      ra_reg  <= repeat_busy_i;  // RULE6
      pri_reg <= pri_next;
      ext_reg <= ext_next;
      if (cc_we_i) psv_reg <= wdata_i[`CAS_CC_PSV_BIT];  // RULE14
      if (alu_fire) begin
        n_reg <= msb;  // RULE7
        z_reg <= (rmask == 16'h0000);  // RULE9
        if (is_arith) begin
          c_reg  <= carry_raw;  // RULE10 RULE11
          dc_reg <= hc_raw;  // RULE1
          ov_reg <= ov_raw;  // RULE8
        end
      end else if (sr_we_i) begin
        dc_reg <= wdata_i[`CAS_SR_DC_BIT];
        n_reg  <= wdata_i[`CAS_SR_N_BIT];
        ov_reg <= wdata_i[`CAS_SR_OV_BIT];
        z_reg  <= wdata_i[`CAS_SR_Z_BIT];
        c_reg  <= wdata_i[`CAS_SR_C_BIT];
      end
    end
  end

  assign alu_status_o = {7'h00, dc_reg, pri_reg, ra_reg, n_reg, ov_reg, z_reg, c_reg};  // RULE12 RULE2
  assign core_control_o = {12'h000, ext_reg, psv_reg, 2'b00};
  assign cpu_priority_o = {ext_reg, pri_reg};  // RULE4
  assign user_irq_block_o = ext_reg || (pri_reg == `CAS_PRI_TOP);  // RULE5
  assign program_window_enable_o = psv_reg;  // RULE14

  // ------------------------------------------------------------
  // multiplier
  // ------------------------------------------------------------
  logic        sa, sb;
  logic [16:0] ma, mb;
  logic [33:0] prod;
  assign sa = (mul_mode_i == CAS_MUL_SS) || (mul_mode_i == CAS_MUL_SU5);
  assign sb = (mul_mode_i == CAS_MUL_SS) || (mul_mode_i == CAS_MUL_US);
  always_comb begin
    ma = {sa & mul_a_i[15], mul_a_i};
    mb = {sb & mul_b_i[15], mul_b_i};
    unique case (mul_mode_i)
      CAS_MUL_SU5, CAS_MUL_UU5: mb = {12'h000, mul_b_i[4:0]};
      CAS_MUL_BB: begin
        ma = {9'h000, mul_a_i[7:0]};
        mb = {9'h000, mul_b_i[7:0]};
      end
      default: ;
    endcase
  end
  // the 34-bit target widens both signed operands before the product is formed
  assign prod = $signed(ma) * $signed(mb);  // RULE17
  always_ff @(posedge clk_i) begin
    if (rst_i) mul_prod_o <= 32'h0000_0000;
    else if (mul_go_i) mul_prod_o <= prod[31:0];
  end

  // ------------------------------------------------------------
  // divider: 16 steps, then fix-up cycles up to cycle 19
  // ------------------------------------------------------------
  cas_div_st_t st_reg;
  logic [4:0]  cnt_reg;
  logic [31:0] dvd_reg;
  logic [16:0] rem_reg;
  logic [15:0] dsr_reg;
  logic        neg_q_reg, neg_r_reg;
  logic [31:0] dvd_in;
  logic [15:0] dsr_abs;
  logic [31:0] dvd_abs;
  logic [16:0] rem_sh;
  logic [16:0] rem_nx;

  assign dvd_in  = div_long_i ? {div_odd_i, div_even_i}
                              : {{16{div_signed_i & div_even_i[15]}}, div_even_i};  // RULE19
  assign dsr_abs = (div_signed_i && div_divisor_i[15]) ? 16'(-div_divisor_i) : div_divisor_i;
  assign dvd_abs = (div_signed_i && dvd_in[31]) ? 32'(-dvd_in) : dvd_in;
  assign rem_sh  = {rem_reg[15:0], dvd_reg[31]};
  // non-restoring step: add or subtract by sign of the partial remainder
  assign rem_nx  = rem_reg[16] ? rem_sh + {1'b0, dsr_reg} : rem_sh - {1'b0, dsr_reg};

  always_ff @(posedge clk_i) begin
    if (rst_i || div_abort_i) begin  // RULE21
      st_reg     <= CAS_DIV_IDLE;
      cnt_reg    <= 5'h00;
      dvd_reg    <= 32'h0000_0000;
      rem_reg    <= 17'h00000;
      dsr_reg    <= 16'h0000;
      neg_q_reg  <= 1'b0;
      neg_r_reg  <= 1'b0;
    end else begin
      unique case (st_reg)
        CAS_DIV_IDLE: if (div_go_i) begin
          st_reg    <= CAS_DIV_RUN;
          cnt_reg   <= 5'h01;
          dvd_reg   <= {dvd_abs[15:0], 16'h0000};
          rem_reg   <= {1'b0, dvd_abs[31:16]};
          dsr_reg   <= dsr_abs;  // RULE19
          neg_q_reg <= div_signed_i && (dvd_in[31] ^ div_divisor_i[15]);
          neg_r_reg <= div_signed_i && dvd_in[31];
        end
        CAS_DIV_RUN: begin  // RULE20
          rem_reg <= rem_nx;
          dvd_reg <= {dvd_reg[30:0], ~rem_nx[16]};
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == 5'h10) st_reg <= CAS_DIV_FIX;
        end
        CAS_DIV_FIX: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == 5'h11) begin
            if (rem_reg[16]) rem_reg <= rem_reg + {1'b0, dsr_reg};
          end else if (cnt_reg == `CAS_DIV_CYCLES) begin
            st_reg <= CAS_DIV_IDLE;
          end
        end
        default: st_reg <= CAS_DIV_IDLE;
      endcase
    end
  end
  // a 32/16 divide runs the low 16 dividend bits after the high half is
  // preloaded; quotients that do not fit 16 bits are not flagged and leave no valid result
  assign div_busy_o = (st_reg != CAS_DIV_IDLE);
  assign div_done_o = (st_reg == CAS_DIV_FIX) && (cnt_reg == `CAS_DIV_CYCLES);  // RULE21
  assign first_work_reg_o  = neg_q_reg ? 16'(-dvd_reg[15:0]) : dvd_reg[15:0];  // RULE18
  assign second_work_reg_o = neg_r_reg ? 16'(-rem_reg[15:0]) : rem_reg[15:0];  // RULE18

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_div_nineteen: assert property (@(posedge clk_i) disable iff (rst_i || div_abort_i)
    (!div_busy_o && div_go_i) |=> div_busy_o [*8] ##11 div_done_o)  // RULE21
    else $error("divide did not finish in 19 cycles");
  a_pri_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    (nesting_off_bit_i && !pri_raise_i) |=> $stable(alu_status_o[7:5]))  // RULE3
    else $error("priority field changed while locked");
  a_irq_block: assert property (@(posedge clk_i) disable iff (rst_i)
    user_irq_block_o == (cpu_priority_o[3] || cpu_priority_o[2:0] == 3'h7))  // RULE5
    else $error("interrupt inhibit wrong");
  a_ra_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    repeat_busy_i |=> alu_status_o[4])  // RULE6
    else $error("repeat flag not set");
  a_zero_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (alu_fire && rmask != 16'h0) |=> !alu_status_o[1])  // RULE9
    else $error("zero flag not cleared");
  a_ext_noset: assert property (@(posedge clk_i) disable iff (rst_i)
    (!core_control_o[3] && !pri_raise_i) |=> !core_control_o[3])  // RULE13
    else $error("extension bit set by software");
  a_hi_zero: assert property (@(posedge clk_i) alu_status_o[15:9] == 7'h00)  // RULE12
    else $error("unimplemented status bits set");
  a_shift_block: assert property (@(posedge clk_i) disable iff (rst_i)
    shift_mode_err_o |=> !res_o.wr_work && !res_o.wr_mem)  // RULE23
    else $error("memory shift was executed");
  a_psv_write: assert property (@(posedge clk_i) disable iff (rst_i)
    cc_we_i |=> program_window_enable_o == $past(wdata_i[2]))  // RULE14
    else $error("window enable not written");
endmodule : cas_datapath

// ==== tb_top.sv ====
// self-checking testbench for the cpu alu status datapath
`timescale 1ns/1ps
module tb_top
  import cas_pkg::*;
;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic         clk_i;
  logic         rst_i;
  cas_alu_req_t req_i;
  cas_alu_res_t res_o;
  cas_mul_t     mul_mode_i;
  logic [15:0]  work_opnd_i, mem_opnd_i, opnd_b_i, mul_a_i, mul_b_i, wdata_i;
  logic [15:0]  div_even_i, div_odd_i, div_divisor_i, first_work_reg_o, second_work_reg_o;
  logic [15:0]  alu_status_o, core_control_o;
  logic [31:0]  mul_prod_o;
  logic [3:0]   pri_new_i, cpu_priority_o;
  logic         shift_mode_err_o, mul_go_i, div_go_i, div_signed_i, div_long_i, div_abort_i;
  logic         div_busy_o, div_done_o, sr_we_i, cc_we_i, nesting_off_bit_i, repeat_busy_i;
  logic         pri_raise_i, user_irq_block_o, program_window_enable_o;
  int           errors;
  int           samples_checked;

  cas_datapath uut (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .work_opnd_i(work_opnd_i), .mem_opnd_i(mem_opnd_i),
    .opnd_b_i(opnd_b_i), .res_o(res_o), .shift_mode_err_o(shift_mode_err_o), .mul_go_i(mul_go_i),
    .mul_mode_i(mul_mode_i), .mul_a_i(mul_a_i), .mul_b_i(mul_b_i), .mul_prod_o(mul_prod_o),
    .div_go_i(div_go_i), .div_signed_i(div_signed_i), .div_long_i(div_long_i), .div_abort_i(div_abort_i),
    .div_even_i(div_even_i), .div_odd_i(div_odd_i), .div_divisor_i(div_divisor_i), .div_busy_o(div_busy_o),
    .div_done_o(div_done_o), .first_work_reg_o(first_work_reg_o), .second_work_reg_o(second_work_reg_o),
    .sr_we_i(sr_we_i), .cc_we_i(cc_we_i), .wdata_i(wdata_i), .nesting_off_bit_i(nesting_off_bit_i),
    .repeat_busy_i(repeat_busy_i), .pri_raise_i(pri_raise_i), .pri_new_i(pri_new_i),
    .alu_status_o(alu_status_o), .core_control_o(core_control_o), .cpu_priority_o(cpu_priority_o),
    .user_irq_block_o(user_irq_block_o), .program_window_enable_o(program_window_enable_o)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // inputs always change 1 ns after the rising edge
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick

  function automatic cas_alu_req_t rq(input cas_op_t op, input logic bm, input logic sm, input logic dm,
                                      input logic cl, input logic [3:0] lc);
    return '{valid: 1'b1, op: op, byte_mode: bm, src_mem: sm, dst_mem: dm, cnt_lit: cl, lit_cnt: lc};
  endfunction : rq

  // valid is left high so back-to-back calls need no gap cycle
  task automatic alu(input cas_alu_req_t r, input logic [15:0] a, input logic [15:0] b,
                     input logic [15:0] exp_d, input logic [15:0] exp_sr);
    req_i       = r;
    work_opnd_i = a;
    opnd_b_i    = b;
    tick;
    check("alu result", {16'h0000, res_o.data}, {16'h0000, exp_d});
    check("alu dest", {30'h0, res_o.wr_work, res_o.wr_mem}, {30'h0, ~r.dst_mem, r.dst_mem});
    check("alu status", {16'h0000, alu_status_o}, {16'h0000, exp_sr});
  endtask : alu

  task automatic mul(input cas_mul_t m, input logic [15:0] a, input logic [15:0] b, input logic [31:0] exp);
    mul_go_i   = 1'b1;
    mul_mode_i = m;
    mul_a_i    = a;
    mul_b_i    = b;
    tick;
    check("product", mul_prod_o, exp);
  endtask : mul

  task automatic div(input logic sg, input logic lg, input logic [15:0] hi, input logic [15:0] lo,
                     input logic [15:0] dv, input logic [15:0] q, input logic [15:0] rm);
    int n;
    div_signed_i  = sg;
    div_long_i    = lg;
    div_odd_i     = hi;
    div_even_i    = lo;
    div_divisor_i = dv;
    div_go_i      = 1'b1;
    tick;
    div_go_i = 1'b0;
    n        = 1;
    while (div_done_o !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    check("divide cycles", n, 19);
    if (n == 40) test_done;
    check("quotient", {16'h0000, first_work_reg_o}, {16'h0000, q});
    check("remainder", {16'h0000, second_work_reg_o}, {16'h0000, rm});
    tick;
  endtask : div

  task automatic wreg(input logic sr, input logic cc, input logic [15:0] d);
    sr_we_i = sr;
    cc_we_i = cc;
    wdata_i = d;
    tick;
  endtask : wreg

  task automatic pri_chk(input logic [15:0] sr, input logic [15:0] cc, input logic [3:0] p, input logic blk);
    check("status reg", {16'h0000, alu_status_o}, {16'h0000, sr});
    check("control reg", {16'h0000, core_control_o}, {16'h0000, cc});
    check("cpu priority", {28'h0, cpu_priority_o}, {28'h0, p});
    check("irq block", {31'h0, user_irq_block_o}, {31'h0, blk});
    check("window", {31'h0, program_window_enable_o}, {31'h0, cc[2]});
  endtask : pri_chk

  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    test_done;
  end

  initial begin
    errors = 0; samples_checked = 0; rst_i = 1'b1; req_i = '0; work_opnd_i = 16'h0000;
    mem_opnd_i = 16'h1234; opnd_b_i = 16'h0000; mul_go_i = 1'b0; mul_mode_i = CAS_MUL_SS;
    mul_a_i = 16'h0000; mul_b_i = 16'h0000; div_go_i = 1'b0; div_signed_i = 1'b0; div_long_i = 1'b0;
    div_abort_i = 1'b0; div_even_i = 16'h0000; div_odd_i = 16'h0000; div_divisor_i = 16'h0001;
    sr_we_i = 1'b0; cc_we_i = 1'b0; wdata_i = 16'h0000; nesting_off_bit_i = 1'b0;
    repeat_busy_i = 1'b0; pri_raise_i = 1'b0; pri_new_i = 4'h0;
    repeat (8) tick;
    rst_i = 1'b0;
    pri_chk(16'h0000, 16'h0000, 4'h0, 1'b0);
    $display("test reset done");
    alu(rq(CAS_OP_ADD, 0, 0, 0, 0, 4'h0), 16'h7FFF, 16'h0001, 16'h8000, 16'h010C);
    alu(rq(CAS_OP_ADD, 0, 0, 0, 0, 4'h0), 16'hFFFF, 16'h0001, 16'h0000, 16'h0103);
    alu(rq(CAS_OP_AND, 0, 0, 0, 0, 4'h0), 16'h0001, 16'h0001, 16'h0001, 16'h0101);
    alu(rq(CAS_OP_SUB, 0, 0, 0, 0, 4'h0), 16'h0005, 16'h0003, 16'h0002, 16'h0101);
    alu(rq(CAS_OP_SUB, 0, 0, 0, 0, 4'h0), 16'h0003, 16'h0005, 16'hFFFE, 16'h0008);
    alu(rq(CAS_OP_SUB, 0, 0, 0, 0, 4'h0), 16'h8000, 16'h0001, 16'h7FFF, 16'h0005);
    alu(rq(CAS_OP_ADD, 1, 0, 0, 0, 4'h0), 16'h000F, 16'h0001, 16'h0010, 16'h0100);
    alu(rq(CAS_OP_ADD, 1, 0, 0, 0, 4'h0), 16'hAB80, 16'h0080, 16'h0000, 16'h0007);
    alu(rq(CAS_OP_XOR, 0, 0, 0, 0, 4'h0), 16'h00FF, 16'h00FF, 16'h0000, 16'h0007);
    alu(rq(CAS_OP_OR, 0, 0, 0, 0, 4'h0), 16'h8000, 16'h0000, 16'h8000, 16'h000D);
    alu(rq(CAS_OP_ASR, 0, 0, 0, 1, 4'hF), 16'h8000, 16'h0000, 16'hFFFF, 16'h000D);
    alu(rq(CAS_OP_LSR, 0, 0, 0, 1, 4'hF), 16'h8000, 16'h0000, 16'h0001, 16'h0005);
    alu(rq(CAS_OP_SL, 0, 0, 0, 1, 4'hF), 16'h0001, 16'h0000, 16'h8000, 16'h000D);
    alu(rq(CAS_OP_ASR, 0, 0, 0, 0, 4'h0), 16'hF000, 16'h0004, 16'hFF00, 16'h000D);
    alu(rq(CAS_OP_LSR, 0, 0, 0, 0, 4'h0), 16'hF000, 16'h0004, 16'h0F00, 16'h0005);
    alu(rq(CAS_OP_MOV, 0, 1, 1, 0, 4'h0), 16'h5678, 16'h0000, 16'h1234, 16'h0005);
    req_i = rq(CAS_OP_ASR, 0, 1, 0, 1, 4'h3);
    #1;
    check("shift refused", {31'h0, shift_mode_err_o}, 32'h1);
    tick;
    req_i.valid = 1'b0;
    check("refused dest", {30'h0, res_o.wr_work, res_o.wr_mem}, 32'h0);
    check("refused status", {16'h0000, alu_status_o}, 32'h0005);
    $display("test alu done");
    mul(CAS_MUL_SS, 16'hFFFE, 16'h0003, 32'hFFFFFFFA);
    mul(CAS_MUL_UU, 16'hFFFF, 16'hFFFF, 32'hFFFE0001);
    mul(CAS_MUL_SU5, 16'hFFFE, 16'h001F, 32'hFFFFFFC2);
    mul(CAS_MUL_UU5, 16'hFFFF, 16'h001F, 32'h001EFFE1);
    mul(CAS_MUL_US, 16'hFFFF, 16'hFFFF, 32'hFFFF0001);
    mul(CAS_MUL_BB, 16'h12FF, 16'h34FF, 32'h0000FE01);
    mul_go_i = 1'b0;
    $display("test multiply done");
    div(0, 1, 16'h0001, 16'h0000, 16'h0010, 16'h1000, 16'h0000);
    div(0, 0, 16'h0000, 16'hFFFF, 16'h0010, 16'h0FFF, 16'h000F);
    div(1, 0, 16'hFFFF, 16'hFFF9, 16'h0002, 16'hFFFD, 16'hFFFF);
    div(1, 1, 16'hFFFF, 16'hFFF9, 16'h0002, 16'hFFFD, 16'hFFFF);
    div_go_i = 1'b1;
    tick;
    div_go_i = 1'b0;
    check("div busy", {31'h0, div_busy_o}, 32'h1);
    repeat (3) tick;
    div_abort_i = 1'b1;
    tick;
    div_abort_i = 1'b0;
    check("div aborted", {30'h0, div_busy_o, div_done_o}, 32'h0);
    $display("test divide done");
    wreg(1, 0, 16'hFFFF);
    pri_chk(16'h01EF, 16'h0000, 4'h7, 1'b1);
    nesting_off_bit_i = 1'b1;
    wreg(1, 0, 16'h0000);
    pri_chk(16'h00E0, 16'h0000, 4'h7, 1'b1);
    nesting_off_bit_i = 1'b0;
    repeat_busy_i     = 1'b1;
    wreg(1, 0, 16'h00C0);
    pri_chk(16'h00D0, 16'h0000, 4'h6, 1'b0);
    repeat_busy_i = 1'b0;
    wreg(0, 1, 16'hFFFF);
    pri_chk(16'h00C0, 16'h0004, 4'h6, 1'b0);
    cc_we_i     = 1'b0;
    pri_raise_i = 1'b1;
    pri_new_i   = 4'hA;
    tick;
    pri_raise_i = 1'b0;
    pri_chk(16'h0040, 16'h000C, 4'hA, 1'b1);
    wreg(0, 1, 16'h0000);
    cc_we_i = 1'b0;
    pri_chk(16'h0040, 16'h0000, 4'h2, 1'b0);
    $display("test registers done");
    test_done;
  end
endmodule : tb_top
